// ---- rtl/scan_chain_fault_loader.sv ----
// fault loader: AHB-Lite registers, shared word FIFO, two scan chain drivers,
// paused design clock and design cycle counter
// assumes one AHB-Lite master and a design under test clocked by pausedDesignClock
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "loader_map.svh"

// Behaviour
// - one FIFO written by software feeds both the value chain and the enable chain.
// - the chain that gets shift clocks and data is the value chain while its counter is nonzero, else the enable chain.
// - each shift pops one word, drives it onto the chain with one clock pulse, counts down.
// - after a correct load the loaded chain's counter reads back zero.
// - the design clock stays stopped while either chain is being shifted.
// - the design cycle counter is cleared while the chains are loaded.
// - each chain has its own shift clock and serial data line at its head.
// - the cycle counter counts each design clock and software can read it.
// - the design clock output is derived from the system clock.
module scan_chain_fault_loader import loader_pkg::*; #(
    parameter int CNT_W = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // scan chains and design clock
    output logic valueChainShiftClock,
    output logic [`LDR_CHAIN_BITS-1:0] valueChainSerialIn,
    output logic enableChainShiftClock,
    output logic [`LDR_CHAIN_BITS-1:0] enableChainSerialIn,
    output logic pausedDesignClock
);

    localparam int PTR_W = $clog2(DEPTH);

    bus_phase_type phase_reg, phase_next;
    logic ready_reg, ready_next;
    logic [31:0] rdata_reg, rdata_next;
    logic fifoPush, valueWrite, enableWrite;
    logic [31:0] readWord;

    logic [`LDR_CHAIN_BITS-1:0] fifoMem [DEPTH];
    logic [PTR_W-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [PTR_W:0] fill_reg, fill_next;
    logic fifoFull, fifoEmpty, fifoPop;
    logic [`LDR_CHAIN_BITS-1:0] headWord;

    shift_state_type state_reg, state_next;
    logic selValue_reg, selValue_next;
    logic selValue, busyAny;
    logic [CNT_W-1:0] valueCount, enableCount;
    chain_drive_type valueDrive, enableDrive;

    logic designClk_reg, designClk_next;
    logic [31:0] cycle_reg, cycle_next;

    // bus slave: every transfer takes one wait state, a write into a full FIFO more, so hreadyout and hrdata come from flops and hresp is tied to OKAY
    always_comb begin
        readWord = `LDR_ZERO_WORD;
        unique case (phase_reg.addr)
            `LDR_VALUE_COUNT_ADDR: readWord[CNT_W-1:0] = valueCount;
            `LDR_ENABLE_COUNT_ADDR: readWord[CNT_W-1:0] = enableCount;
            `LDR_CYCLE_COUNT_ADDR: readWord = cycle_reg;
            `LDR_STATUS_ADDR: begin
                readWord[PTR_W:0] = fill_reg;
                readWord[`LDR_STATUS_BUSY_BIT] = busyAny;
            end
            default: readWord = `LDR_ZERO_WORD;
        endcase
    end

    always_comb begin
        phase_next = phase_reg;
        ready_next = ready_reg;
        rdata_next = rdata_reg;
        fifoPush = 1'b0;
        valueWrite = 1'b0;
        enableWrite = 1'b0;
        if (phase_reg.valid && !ready_reg) begin
            if (!phase_reg.write) begin
                rdata_next = readWord;
                ready_next = 1'b1;
                phase_next.valid = 1'b0;
            end else if (phase_reg.addr == `LDR_FIFO_DATA_ADDR) begin
                // a full FIFO stalls the bus instead of dropping the word
                if (!fifoFull) begin
                    fifoPush = 1'b1;
                    ready_next = 1'b1;
                    phase_next.valid = 1'b0;
                end
            end else begin
                valueWrite = (phase_reg.addr == `LDR_VALUE_COUNT_ADDR);
                enableWrite = (phase_reg.addr == `LDR_ENABLE_COUNT_ADDR);
                ready_next = 1'b1;
                phase_next.valid = 1'b0;
            end
        end else if (hsel && hready && htrans[`LDR_HTRANS_ACTIVE_BIT]) begin
            phase_next.valid = 1'b1;
            phase_next.write = hwrite;
            phase_next.addr = haddr[`LDR_ADDR_BITS-1:0];
            ready_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_reg <= '0;
            ready_reg <= 1'b1;
            rdata_reg <= `LDR_ZERO_WORD;
        end else begin
            phase_reg <= phase_next;
            ready_reg <= ready_next;
            rdata_reg <= rdata_next;
        end
    end

    assign hreadyout = ready_reg;
    assign hrdata = rdata_reg;
    assign hresp = `LDR_HRESP_OKAY;

    // shared word FIFO
    assign fifoFull = (fill_reg == (PTR_W+1)'(DEPTH));
    assign fifoEmpty = (fill_reg == '0);
    assign headWord = fifoMem[rdPtr_reg];

    always_comb begin
        wrPtr_next = fifoPush ? wrPtr_reg + 1'b1 : wrPtr_reg;
        rdPtr_next = fifoPop ? rdPtr_reg + 1'b1 : rdPtr_reg;
        fill_next = fill_reg + {{PTR_W{1'b0}}, fifoPush} - {{PTR_W{1'b0}}, fifoPop};
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            fill_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            fill_reg <= fill_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (fifoPush) begin
            fifoMem[wrPtr_reg] <= hwdata;
        end
    end

    // shift engine: pop, data settles a cycle, clock high a cycle, clock low
    assign selValue = (valueCount != '0);
    assign busyAny = selValue || (enableCount != '0) || (state_reg != SHIFT_IDLE);
    // leftover words wait while both counts are zero
    assign fifoPop = (state_reg == SHIFT_IDLE) && (valueCount != '0 || enableCount != '0)
        && !fifoEmpty && !designClk_reg;

    always_comb begin
        state_next = state_reg;
        selValue_next = selValue_reg;
        unique case (state_reg)
            SHIFT_IDLE: begin
                if (fifoPop) begin
                    state_next = SHIFT_HIGH;
                    selValue_next = selValue;
                end
            end
            SHIFT_HIGH: state_next = SHIFT_LOW;
            SHIFT_LOW: state_next = SHIFT_IDLE;
            default: state_next = SHIFT_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= SHIFT_IDLE;
            selValue_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            selValue_reg <= selValue_next;
        end
    end

    chain_shift_port #(.CNT_W(CNT_W)) valuePort (
        .clk_sys(clk_sys),
        .srst(srst),
        .countWrite(valueWrite),
        .countWriteData(hwdata[CNT_W-1:0]),
        .popLoad(fifoPop && selValue),
        .popWord(headWord),
        .pulseHigh(state_reg == SHIFT_HIGH && selValue_reg),
        .count_reg(valueCount),
        .drive_reg(valueDrive)
    );

    chain_shift_port #(.CNT_W(CNT_W)) enablePort (
        .clk_sys(clk_sys),
        .srst(srst),
        .countWrite(enableWrite),
        .countWriteData(hwdata[CNT_W-1:0]),
        .popLoad(fifoPop && !selValue),
        .popWord(headWord),
        .pulseHigh(state_reg == SHIFT_HIGH && !selValue_reg),
        .count_reg(enableCount),
        .drive_reg(enableDrive)
    );

    assign valueChainShiftClock = valueDrive.shiftClock;
    assign valueChainSerialIn = valueDrive.serialIn;
    assign enableChainShiftClock = enableDrive.shiftClock;
    assign enableChainSerialIn = enableDrive.serialIn;

    // design clock at half the system rate, held low while loading
    always_comb begin
        designClk_next = busyAny ? 1'b0 : !designClk_reg;
        if (busyAny) begin
            cycle_next = `LDR_ZERO_WORD;
        end else if (!designClk_reg) begin
            cycle_next = cycle_reg + 32'h0000_0001;
        end else begin
            cycle_next = cycle_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            designClk_reg <= 1'b0;
            cycle_reg <= `LDR_ZERO_WORD;
        end else begin
            designClk_reg <= designClk_next;
            cycle_reg <= cycle_next;
        end
    end

    assign pausedDesignClock = designClk_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_pulse(logic clkSig);
        !clkSig ##1 clkSig ##1 !clkSig;
    endsequence

    property p_shared_fifo;
        fifoPop |=> (selValue_reg ? valueDrive.serialIn : enableDrive.serialIn) == $past(headWord);
    endproperty
    a_shared_fifo: assert property (p_shared_fifo) else $error("popped word not on chain");

    property p_select;
        enableDrive.shiftClock |-> $past(enableCount, 2) != '0 && $past(valueCount, 2) == '0;
    endproperty
    a_select: assert property (p_select) else $error("chain shifted with zero count");

    property p_pulse;
        fifoPop && selValue |=> s_pulse(valueDrive.shiftClock) ##0 !enableDrive.shiftClock;
    endproperty
    a_pulse: assert property (p_pulse) else $error("value chain pulse malformed");

    property p_count_down;
        fifoPop && !selValue && !enableWrite |=> enableCount == $past(enableCount) - 1'b1;
    endproperty
    a_count_down: assert property (p_count_down) else $error("enable count not decremented");

    property p_clock_paused;
        busyAny |=> !designClk_reg;
    endproperty
    a_clock_paused: assert property (p_clock_paused) else $error("design clock ran in load");

    property p_cycle_clear;
        busyAny |=> cycle_reg == `LDR_ZERO_WORD;
    endproperty
    a_cycle_clear: assert property (p_cycle_clear) else $error("cycle count not cleared");

    property p_data_stable;
        valueDrive.shiftClock |-> $stable(valueDrive.serialIn) && selValue_reg;
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved under clock");

    property p_cycle_count;
        !busyAny && !designClk_reg |=> designClk_reg && cycle_reg == $past(cycle_reg) + 1;
    endproperty
    a_cycle_count: assert property (p_cycle_count) else $error("design cycle not counted");

    property p_free_run;
        !busyAny |-> !fifoPop ##1 (busyAny || designClk_reg != $past(designClk_reg));
    endproperty
    a_free_run: assert property (p_free_run) else $error("idle loader misbehaved");

endmodule

// ---- rtl/loader_map.svh ----
// register map, field positions, reset values and encodings of the fault loader
// assumes a 32-bit AHB-Lite slave port decoding the low address byte
`ifndef LOADER_MAP_SVH
`define LOADER_MAP_SVH

`define LDR_ADDR_BITS 8
`define LDR_VALUE_COUNT_ADDR 8'h00
`define LDR_ENABLE_COUNT_ADDR 8'h04
`define LDR_CYCLE_COUNT_ADDR 8'h08
`define LDR_FIFO_DATA_ADDR 8'h0c
`define LDR_STATUS_ADDR 8'h10
`define LDR_STATUS_BUSY_BIT 31
`define LDR_CHAIN_BITS 32
`define LDR_ZERO_WORD 32'h0000_0000
`define LDR_HTRANS_ACTIVE_BIT 1
`define LDR_HRESP_OKAY 1'b0

`endif

// ---- rtl/loader_pkg.sv ----
// types shared by the fault loader and its per-chain shift port
// assumes loader_map.svh is on the include path
`include "loader_map.svh"

package loader_pkg;

    typedef enum logic [1:0] {
        SHIFT_IDLE = 2'b00,
        SHIFT_HIGH = 2'b01,
        SHIFT_LOW = 2'b10
    } shift_state_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [`LDR_ADDR_BITS-1:0] addr;
    } bus_phase_type;

    typedef struct packed {
        logic shiftClock;
        logic [`LDR_CHAIN_BITS-1:0] serialIn;
    } chain_drive_type;

endpackage

// ---- rtl/chain_shift_port.sv ----
// one scan chain port: pending shift count, serial word and shift clock
// assumes the caller loads a word and pulses the clock a cycle later
`timescale 1ns/10ps
`include "loader_map.svh"

module chain_shift_port import loader_pkg::*; #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // software count access
    input wire logic countWrite,
    input wire logic [CNT_W-1:0] countWriteData,
    // shift engine
    input wire logic popLoad,
    input wire logic [`LDR_CHAIN_BITS-1:0] popWord,
    input wire logic pulseHigh,
    // results
    output logic [CNT_W-1:0] count_reg,
    output chain_drive_type drive_reg
);

    logic [CNT_W-1:0] count_next;
    chain_drive_type drive_next;

    always_comb begin
        count_next = count_reg;
        // a software write takes over the count even mid-load
        if (countWrite) begin
            count_next = countWriteData;
        end else if (popLoad) begin
            count_next = count_reg - 1'b1;
        end
        drive_next.serialIn = popLoad ? popWord : drive_reg.serialIn;
        drive_next.shiftClock = pulseHigh;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count_reg <= '0;
            drive_reg <= '0;
        end else begin
            count_reg <= count_next;
            drive_reg <= drive_next;
        end
    end

endmodule

// ---- sim/fault_design_model.sv ----
// model of the fault-enabled design: two banks of 32 scan chains and a cycle count
// assumes single-cycle shift pulses and a design clock supplied by the loader
`timescale 1ns/10ps

module fault_design_model #(
    parameter int DEPTH = 4
) (
    // clocks from the loader
    input wire logic designClock,
    input wire logic valueShiftClock,
    input wire logic enableShiftClock,
    // words at the chain heads
    input wire logic [31:0] valueSerialIn,
    input wire logic [31:0] enableSerialIn,
    // observed state
    output logic [31:0] valueChain [DEPTH],
    output logic [31:0] enableChain [DEPTH],
    output int cycles,
    output int valuePulses,
    output int enablePulses
);
    initial begin
        valueChain = '{default: 32'h0};
        enableChain = '{default: 32'h0};
        cycles = 0;
        valuePulses = 0;
        enablePulses = 0;
    end

    // each chain moves only on its own pulse, head first
    always @(posedge valueShiftClock) begin
        for (int i = DEPTH - 1; i > 0; i--) valueChain[i] <= valueChain[i-1];
        valueChain[0] <= valueSerialIn;
        valuePulses <= valuePulses + 1;
    end

    always @(posedge enableShiftClock) begin
        for (int i = DEPTH - 1; i > 0; i--) enableChain[i] <= enableChain[i-1];
        enableChain[0] <= enableSerialIn;
        enablePulses <= enablePulses + 1;
    end

    always @(posedge designClock) cycles <= cycles + 1;
endmodule

// ---- sim/scan_chain_fault_loader_test.sv ----
// self-checking bench of the fault loader over AHB-Lite
// assumes one master, hready tied to hreadyout, chain model on the far side
`timescale 1ns/10ps
`include "loader_map.svh"

module scan_chain_fault_loader_test import loader_pkg::*;;
    localparam int D = 4;
    logic clk_sys;
    logic srst = 1'b1;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, vClk, eClk, dClk;
    logic [31:0] hrdata, vIn, eIn, r1, r2;
    logic [31:0] vChain [D];
    logic [31:0] eChain [D];
    logic [7:0] a, b;
    logic [31:0] loQ[$];
    logic [31:0] hiQ[$];
    logic rdPend = 1'b0;
    int cyc, vP, eP, c0, p, k, fault;
    int errors = 0;
    int numChecks = 0;

    scan_chain_fault_loader #(.CNT_W(16), .DEPTH(16)) uut (.clk_sys(clk_sys), .srst(srst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .valueChainShiftClock(vClk), .valueChainSerialIn(vIn),
        .enableChainShiftClock(eClk), .enableChainSerialIn(eIn), .pausedDesignClock(dClk));

    fault_design_model #(.DEPTH(D)) chains (.designClock(dClk), .valueShiftClock(vClk),
        .enableShiftClock(eClk), .valueSerialIn(vIn), .enableSerialIn(eIn),
        .valueChain(vChain), .enableChain(eChain), .cycles(cyc), .valuePulses(vP),
        .enablePulses(eP));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task check(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        numChecks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("MISMATCH %0t got %h want %h..%h", $time, got, lo, hi);
        end
    endtask

    // request held until hready is seen high, data phase likewise
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] d, output logic [31:0] q);
        hwrite <= w;
        haddr <= {24'h0, ad};
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, ad, d, q);
    endtask

    task rd(input logic [7:0] ad, input logic [31:0] lo, input logic [31:0] hi);
        logic [31:0] q;
        loQ.push_back(lo);
        hiQ.push_back(hi);
        bus(1'b0, ad, 32'h0, q);
    endtask

    // busy covers pending counts and a shift in flight
    task poll_idle;
        logic [31:0] q;
        q = 32'h8000_0000;
        repeat (200) if (q[`LDR_STATUS_BUSY_BIT] !== 1'b0) bus(1'b0, `LDR_STATUS_ADDR, 0, q);
    endtask

    function logic [31:0] word(input int n);
        return (n == fault / 32) ? 32'h1 << (fault % 32) : 32'h0;
    endfunction

    // read data is taken at the edge that ends the data phase
    always @(posedge clk_sys) begin
        if (rdPend && hreadyout === 1'b1 && loQ.size() > 0) begin
            check(hrdata, loQ.pop_front(), hiQ.pop_front());
            check({31'h0, hresp}, 32'h0, 32'h0);
        end
        // a note must exist when the read is taken, so status polls never eat one
        if (hreadyout === 1'b1) rdPend = htrans[1] && !hwrite && loQ.size() > 0;
    end

    task print_verdict;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        print_verdict;
    end

    initial begin
        void'($urandom(20));
        fault = $urandom_range(32 * D - 1);
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (100) @(posedge clk_sys);
        rd(`LDR_CYCLE_COUNT_ADDR, 45, 60);
        rd(`LDR_VALUE_COUNT_ADDR, 0, 0);
        rd(8'h14, 0, 0);
        // value pass first, enable pass second
        for (p = 0; p < 2; p++) begin
            a = p ? `LDR_ENABLE_COUNT_ADDR : `LDR_VALUE_COUNT_ADDR;
            b = p ? `LDR_VALUE_COUNT_ADDR : `LDR_ENABLE_COUNT_ADDR;
            wr(a, D);
            wr(b, 0);
            rd(a, D, D);
            repeat (2) @(posedge clk_sys);
            c0 = cyc;
            for (k = 0; k < D; k++) wr(`LDR_FIFO_DATA_ADDR, word(k));
            poll_idle;
            check(cyc, c0, c0 + 2);
            rd(a, 0, 0);
            rd(`LDR_CYCLE_COUNT_ADDR, 0, 8);
        end
        for (k = 0; k < D; k++) begin
            check(vChain[D-1-k], word(k), word(k));
            check(eChain[D-1-k], word(k), word(k));
        end
        check(vP, D, D);
        check(eP, D, D);
        // words pushed with both counts zero must wait
        r1 = $urandom;
        r2 = $urandom;
        wr(`LDR_FIFO_DATA_ADDR, r1);
        wr(`LDR_FIFO_DATA_ADDR, r2);
        c0 = cyc;
        repeat (40) @(posedge clk_sys);
        check(cyc - c0, 20, 20);
        rd(`LDR_STATUS_ADDR, 2, 2);
        check(vP, D, D);
        wr(`LDR_VALUE_COUNT_ADDR, 2);
        poll_idle;
        check(vChain[1], r1, r1);
        check(vChain[0], r2, r2);
        check(eP, D, D);
        rd(`LDR_STATUS_ADDR, 0, 0);
        print_verdict;
    end
endmodule
